//--- design/bpc_branch_ctrl.sv
// branch pipeline control: squash, redirect, stack and atomic window
`timescale 1ns/10ps
`default_nettype none
module bpc_branch_ctrl #(
   parameter int PC_W = bpc_pkg::PC_W,
   parameter int DEPTH = bpc_pkg::STACK_DEPTH,
   parameter int PW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // instruction in decode stage
   input wire logic dec_valid,
   input wire logic dec_branch,
   input wire bpc_pkg::bpc_kind_t dec_kind,
   input wire logic delayed_branch_modifier,
   input wire logic dec_conditional,
   input wire logic dec_cond_true,
   input wire logic [PC_W-1:0] dec_pc,
   input wire logic [PC_W-1:0] dec_target,
   input wire logic dec_idle,
   // explicit stack access from execute
   input wire logic sw_push,
   input wire logic sw_pop,
   input wire logic [PC_W-1:0] sw_push_data,
   input wire logic sw_top_wr,
   input wire logic [PC_W-1:0] sw_top_data,
   // interrupt latch side
   input wire logic irq_pending,
   output logic irq_allow_q,
   output logic rti_clear_q,
   // fetch and pipeline steering
   output logic fetch_redirect_q,
   output logic [PC_W-1:0] fetch_target_q,
   output logic kill_decode_q,
   output logic core_idle_q,
   // stack state
   output logic [PC_W-1:0] pc_stack_top,
   output logic [PW-1:0] pc_stack_pointer,
   output logic pc_stack_empty
);
   bpc_pkg::bpc_state_t state_q;
   bpc_pkg::bpc_kind_t kind_q;
   logic delayed_q;
   logic cond_taken_q;
   logic [PC_W-1:0] pc_q;
   logic [1:0] kill_sched_q;
   logic live;
   logic in_slot1;
   logic excl_nop;
   logic accept;
   logic accept_imm;
   logic stk_push;
   logic stk_pop;
   logic [PC_W-1:0] ret_addr;

   function automatic logic is_return(bpc_pkg::bpc_kind_t k);
      return (k == bpc_pkg::BK_RTS) || (k == bpc_pkg::BK_RTI);
   endfunction

   // ==========================================================
   // branch acceptance
   // a killed decode slot carries a nop and must not branch
   assign live = dec_valid && !kill_decode_q;
   assign in_slot1 = (state_q == bpc_pkg::ST_C2) && delayed_q;
   // second exclusive conditional jump after a taken one is dropped
   assign excl_nop = in_slot1 && cond_taken_q && dec_conditional;
   // only a delayed jump is honoured in the first slot of a delayed
   // jump; anything else there is left to the tools to reject
   assign accept = live && dec_branch && dec_cond_true && !excl_nop &&
      ((state_q == bpc_pkg::ST_IDLE) ||
       (in_slot1 && kind_q == bpc_pkg::BK_JUMP &&
        dec_kind == bpc_pkg::BK_JUMP && delayed_branch_modifier));
   assign accept_imm = accept && !delayed_branch_modifier;

   // ==========================================================
   // phase tracking
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q <= bpc_pkg::ST_IDLE;
      end else if (accept) begin
         state_q <= bpc_pkg::ST_C2;
      end else begin
         unique case (state_q)
            bpc_pkg::ST_IDLE: state_q <= bpc_pkg::ST_IDLE;
            bpc_pkg::ST_C2: state_q <= bpc_pkg::ST_C3;
            bpc_pkg::ST_C3: state_q <= bpc_pkg::ST_C4;
            bpc_pkg::ST_C4: state_q <= bpc_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         kind_q <= bpc_pkg::BK_JUMP;
         delayed_q <= 1'b0;
         cond_taken_q <= 1'b0;
         pc_q <= bpc_pkg::PC_RST;
      end else if (accept) begin
         kind_q <= dec_kind;
         delayed_q <= delayed_branch_modifier;
         cond_taken_q <= dec_conditional;
         pc_q <= dec_pc;
      end
   end

   // ==========================================================
   // squash schedule: immediate kills cycles 2..4, delayed only 4
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         kill_decode_q <= 1'b0;
         kill_sched_q <= 2'h0;
      end else begin
         kill_decode_q <= accept_imm || kill_sched_q[0];
         kill_sched_q[0] <= kill_sched_q[1] || accept_imm;
         kill_sched_q[1] <= accept;
      end
   end

   // ==========================================================
   // fetch redirect; returns take the stack top as target
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         fetch_redirect_q <= 1'b0;
         fetch_target_q <= bpc_pkg::PC_RST;
      end else begin
         fetch_redirect_q <= accept;
         if (accept) begin
            fetch_target_q <= is_return(dec_kind) ? pc_stack_top : dec_target;
         end
      end
   end

   // ==========================================================
   // stack operations of the branch land in cycle 3
   assign stk_push = (state_q == bpc_pkg::ST_C2) &&
      (kind_q == bpc_pkg::BK_CALL);
   assign stk_pop = (state_q == bpc_pkg::ST_C2) && is_return(kind_q);
   assign ret_addr = pc_q + (delayed_q ? bpc_pkg::RET_DLY_OFS :
      bpc_pkg::RET_IMM_OFS);

   // branch push and pop take the stack port; a colliding explicit push or pop
   // is lost, which only illegal slot code can provoke; a top write during a call's push replaces its return address
   // visible from cycle 3 on, so slot reads see it early
   bpc_pc_stack #(
      .DEPTH(DEPTH),
      .W(PC_W),
      .PW(PW)
   ) u_stack (
      .clock(clock),
      .resetn(resetn),
      .push(stk_push || (sw_push && !stk_pop)),
      .pop(stk_pop || (sw_pop && !stk_push)),
      .push_data(stk_push ? ret_addr : sw_push_data),
      .wr_en(sw_top_wr),
      .wr_data(sw_top_data),
      .top_q(pc_stack_top),
      .ptr_q(pc_stack_pointer),
      .empty_q(pc_stack_empty)
   );

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rti_clear_q <= 1'b0;
      end else begin
         rti_clear_q <= stk_pop && (kind_q == bpc_pkg::BK_RTI);
      end
   end

   // ==========================================================
   // interrupt gate: shut from the branch through both slots
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_allow_q <= 1'b1;
      end else begin
         irq_allow_q <= !accept && (state_q == bpc_pkg::ST_IDLE ||
            state_q == bpc_pkg::ST_C4);
      end
   end

   // ==========================================================
   // idle: only an interrupt that may be serviced wakes the core
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         core_idle_q <= 1'b0;
      end else if (core_idle_q) begin
         core_idle_q <= !(irq_pending && irq_allow_q);
      end else begin
         core_idle_q <= live && dec_idle;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence three_kills_s;
      kill_decode_q [*3];
   endsequence
   sequence slots_then_kill_s;
      !kill_decode_q ##1 !kill_decode_q ##1 kill_decode_q;
   endsequence

   imm_three_kills_a: assert property (
      accept_imm |=> three_kills_s ##1 !kill_decode_q)
      else $error("immediate branch did not kill three");
   dly_slot_kill_a: assert property (
      (accept && delayed_branch_modifier && state_q == bpc_pkg::ST_IDLE)
      |=> slots_then_kill_s)
      else $error("delayed branch slot kill wrong");
   imm_call_push_a: assert property (
      (accept_imm && dec_kind == bpc_pkg::BK_CALL) ##1
      (!sw_top_wr && pc_stack_pointer != PW'(DEPTH)) |=>
      (pc_stack_top == $past(dec_pc, 2) + bpc_pkg::RET_IMM_OFS))
      else $error("immediate call pushed wrong address");
   dly_call_push_a: assert property (
      (accept && delayed_branch_modifier && dec_kind == bpc_pkg::BK_CALL)
      ##1 (!sw_top_wr && pc_stack_pointer != PW'(DEPTH)) |=>
      (pc_stack_top == $past(dec_pc, 2) + bpc_pkg::RET_DLY_OFS))
      else $error("delayed call pushed wrong address");
   ret_pop_a: assert property (
      (accept && is_return(dec_kind) && !pc_stack_empty && !sw_push
       && !sw_pop) |=> ##1 (pc_stack_pointer ==
      $past(pc_stack_pointer, 2) - PW'(1)))
      else $error("return did not pop in cycle 3");
   rti_clear_a: assert property (
      (accept_imm && dec_kind == bpc_pkg::BK_RTI) |=> ##1 rti_clear_q)
      else $error("return from interrupt did not clear");
   redirect_a: assert property (
      (accept && !is_return(dec_kind)) |=>
      (fetch_redirect_q && fetch_target_q == $past(dec_target)))
      else $error("redirect target wrong");
   atomic_irq_a: assert property (
      accept |=> !irq_allow_q [*3])
      else $error("interrupt allowed inside delayed branch");
   idle_hold_a: assert property (
      (core_idle_q && !irq_allow_q) |=> core_idle_q)
      else $error("core woke inside delayed branch");
   excl_nop_a: assert property (
      (excl_nop && dec_branch) |=> !fetch_redirect_q)
      else $error("exclusive second jump was taken");
   nested_jump_a: assert property (
      (in_slot1 && accept) |=> (fetch_target_q == $past(dec_target)))
      else $error("slot jump did not win");
endmodule
`default_nettype wire

//--- design/bpc_pc_stack.sv
// program-counter stack with push, pop and top overwrite
`timescale 1ns/10ps
`default_nettype none
module bpc_pc_stack #(
   parameter int DEPTH = bpc_pkg::STACK_DEPTH,
   parameter int W = bpc_pkg::PC_W,
   parameter int PW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // operations
   input wire logic push,
   input wire logic pop,
   input wire logic [W-1:0] push_data,
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   // state
   output logic [W-1:0] top_q,
   output logic [PW-1:0] ptr_q,
   output logic empty_q
);
   logic [W-1:0] mem [DEPTH];
   logic full;
   logic [W-1:0] push_val;

   assign full = (ptr_q == PW'(DEPTH));
   // a top write in the same cycle as a push wins over the pushed value
   assign push_val = wr_en ? wr_data : push_data;

   // ==========================================================
   // storage
   always_ff @(posedge clock) begin
      if (push && !full) begin
         mem[ptr_q] <= push_val;
      end else if (wr_en && !empty_q && !pop) begin
         mem[ptr_q - PW'(1)] <= wr_data;
      end
   end

   // ==========================================================
   // pointer, top copy and empty flag
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ptr_q <= '0;
         top_q <= bpc_pkg::PC_RST;
         empty_q <= 1'b1;
      end else if (push && !full) begin
         ptr_q <= ptr_q + PW'(1);
         top_q <= push_val;
         empty_q <= 1'b0;
      end else if (pop && !empty_q) begin
         ptr_q <= ptr_q - PW'(1);
         top_q <= (ptr_q > PW'(1)) ? mem[ptr_q - PW'(2)] : bpc_pkg::PC_RST;
         empty_q <= (ptr_q == PW'(1));
      end else if (wr_en && !empty_q) begin
         top_q <= wr_data;
      end
      // write into an empty stack without a push is dropped: nothing changes
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   empty_write_a: assert property (
      (wr_en && empty_q && !push) |=> (empty_q && ptr_q == '0))
      else $error("write to empty stack changed it");
   top_overwrite_a: assert property (
      (wr_en && !empty_q && !push && !pop) |=>
      (top_q == $past(wr_data) && ptr_q == $past(ptr_q)))
      else $error("top write did not overwrite");
endmodule
`default_nettype wire

//--- design/bpc_pkg.sv
// package: constants and types for the branch pipeline control block
package bpc_pkg;
   // ==========================================================
   // widths and sizes
   localparam int PC_W = 24;
   localparam int STACK_DEPTH = 30;

   // ==========================================================
   // return address offsets from the branch instruction
   localparam logic [PC_W-1:0] RET_IMM_OFS = 24'h00_0001;
   localparam logic [PC_W-1:0] RET_DLY_OFS = 24'h00_0003;

   // ==========================================================
   // reset values
   localparam logic [PC_W-1:0] PC_RST = 24'h00_0000;

   // ==========================================================
   // branch kinds as decoded
   typedef enum logic [1:0] {
      BK_JUMP = 2'h0,
      BK_CALL = 2'h1,
      BK_RTS  = 2'h2,
      BK_RTI  = 2'h3
   } bpc_kind_t;

   // ==========================================================
   // branch phase, named by pipeline cycle, gray coded
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_C2   = 2'h1,
      ST_C3   = 2'h3,
      ST_C4   = 2'h2
   } bpc_state_t;
endpackage

//--- verification/bpc_irq_latch_model.sv
// interrupt latch model standing beside the branch control block
`timescale 1ns/10ps
`default_nettype none
module bpc_irq_latch_model (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // request from bench, service window from block
   input wire logic irq_raise,
   input wire logic irq_allow_q,
   // latched request
   output logic irq_pending
);
   // ==========================================================
   // latch
   // held until serviced, so a blocked window only delays it
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_pending <= 1'b0;
      end else if (irq_raise) begin
         irq_pending <= 1'b1;
      end else if (irq_pending && irq_allow_q) begin
         irq_pending <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- verification/branch_pipeline_control_tb_top.sv
// testbench for the branch pipeline control block
`timescale 1ns/10ps
`default_nettype none
module branch_pipeline_control_tb_top;
   // ==========================================================
   // signals
   logic clock, resetn, dec_valid, dec_branch, delayed_branch_modifier;
   logic dec_conditional, dec_cond_true, dec_idle, sw_top_wr, irq_raise;
   logic irq_pending, irq_allow_q, rti_clear_q, fetch_redirect_q;
   logic kill_decode_q, core_idle_q, pc_stack_empty;
   logic [23:0] dec_pc, dec_target, sw_top_data, fetch_target_q;
   logic [23:0] pc_stack_top, sw_push_data;
   logic sw_push, sw_pop, keep_branch;
   logic [4:0] pc_stack_pointer;
   bpc_pkg::bpc_kind_t dec_kind;
   int n_errors;
   int samples_checked;

   bpc_branch_ctrl DUT (
      .clock(clock), .resetn(resetn), .dec_valid(dec_valid),
      .dec_branch(dec_branch), .dec_kind(dec_kind),
      .delayed_branch_modifier(delayed_branch_modifier),
      .dec_conditional(dec_conditional), .dec_cond_true(dec_cond_true),
      .dec_pc(dec_pc), .dec_target(dec_target), .dec_idle(dec_idle),
      .sw_push(sw_push), .sw_pop(sw_pop), .sw_push_data(sw_push_data),
      .sw_top_wr(sw_top_wr), .sw_top_data(sw_top_data),
      .irq_pending(irq_pending), .irq_allow_q(irq_allow_q),
      .rti_clear_q(rti_clear_q), .fetch_redirect_q(fetch_redirect_q),
      .fetch_target_q(fetch_target_q), .kill_decode_q(kill_decode_q),
      .core_idle_q(core_idle_q), .pc_stack_top(pc_stack_top),
      .pc_stack_pointer(pc_stack_pointer), .pc_stack_empty(pc_stack_empty)
   );

   bpc_irq_latch_model partner (
      .clock(clock), .resetn(resetn), .irq_raise(irq_raise),
      .irq_allow_q(irq_allow_q), .irq_pending(irq_pending)
   );

   // ==========================================================
   // helpers
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic step;
      @(negedge clock);
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // presents a branch in decode, returns in cycle 2
   task automatic issue(input bpc_pkg::bpc_kind_t k, input logic dly,
                        input logic [23:0] pc, input logic [23:0] tgt);
      dec_branch = 1'b1;
      dec_kind = k;
      delayed_branch_modifier = dly;
      dec_pc = pc;
      dec_target = tgt;
      step;
      // slots hold plain instructions unless a test says otherwise
      if (!keep_branch) begin
         dec_branch = 1'b0;
         delayed_branch_modifier = 1'b0;
      end
   endtask

   // delayed jump in the first slot, returns in cycle 3
   task automatic slot_branch(input logic [23:0] tgt);
      dec_branch = 1'b1;
      delayed_branch_modifier = 1'b1;
      dec_target = tgt;
      step;
      dec_branch = 1'b0;
      delayed_branch_modifier = 1'b0;
      dec_conditional = 1'b0;
   endtask

   task automatic top_write(input logic [23:0] d);
      sw_top_wr = 1'b1;
      sw_top_data = d;
      step;
      sw_top_wr = 1'b0;
   endtask

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_empty_write;
      issue(bpc_pkg::BK_JUMP, 1'b1, 24'h00_0010, 24'h00_0040);
      top_write(24'h00_0abc);
      check(pc_stack_empty, 24'h00_0001);
      check(pc_stack_pointer, 24'h00_0000);
      check(pc_stack_top, 24'h00_0000);
      repeat (3) step;
      $display("empty stack write done");
   endtask

   task automatic t_imm_call;
      issue(bpc_pkg::BK_CALL, 1'b0, 24'h00_0100, 24'h00_0200);
      check(fetch_redirect_q, 24'h00_0001);
      check(fetch_target_q, 24'h00_0200);
      check(kill_decode_q, 24'h00_0001);
      step;
      check(kill_decode_q, 24'h00_0001);
      check(pc_stack_top, 24'h00_0100 + bpc_pkg::RET_IMM_OFS);
      check(pc_stack_pointer, 24'h00_0001);
      step;
      check(kill_decode_q, 24'h00_0001);
      step;
      check(kill_decode_q, 24'h00_0000);
      step;
      $display("immediate call done");
   endtask

   task automatic t_dly_call;
      issue(bpc_pkg::BK_CALL, 1'b1, 24'h00_0300, 24'h00_0800);
      check(fetch_redirect_q, 24'h00_0001);
      check(kill_decode_q, 24'h00_0000);
      check(irq_allow_q, 24'h00_0000);
      step;
      check(kill_decode_q, 24'h00_0000);
      check(pc_stack_top, 24'h00_0300 + bpc_pkg::RET_DLY_OFS);
      check(pc_stack_pointer, 24'h00_0002);
      step;
      check(kill_decode_q, 24'h00_0001);
      check(irq_allow_q, 24'h00_0000);
      step;
      check(kill_decode_q, 24'h00_0000);
      check(irq_allow_q, 24'h00_0001);
      issue(bpc_pkg::BK_CALL, 1'b1, 24'h00_0900, 24'h00_0800);
      top_write(24'h00_0a00);
      check(pc_stack_top, 24'h00_0a00);
      check(pc_stack_pointer, 24'h00_0003);
      repeat (3) step;
      issue(bpc_pkg::BK_JUMP, 1'b1, 24'h00_0a00, 24'h00_0c00);
      top_write(24'h00_0b00);
      check(pc_stack_top, 24'h00_0b00);
      check(pc_stack_pointer, 24'h00_0003);
      repeat (3) step;
      $display("delayed call and top writes done");
   endtask

   task automatic t_dly_rts;
      issue(bpc_pkg::BK_RTS, 1'b1, 24'h00_0d00, 24'h00_0000);
      check(fetch_redirect_q, 24'h00_0001);
      check(fetch_target_q, 24'h00_0b00);
      check(kill_decode_q, 24'h00_0000);
      step;
      check(pc_stack_pointer, 24'h00_0002);
      check(pc_stack_top, 24'h00_0303);
      check(kill_decode_q, 24'h00_0000);
      step;
      check(kill_decode_q, 24'h00_0001);
      step;
      check(kill_decode_q, 24'h00_0000);
      step;
      $display("delayed return done");
   endtask

   task automatic t_rti;
      issue(bpc_pkg::BK_RTI, 1'b0, 24'h00_0e00, 24'h00_0000);
      check(fetch_target_q, 24'h00_0303);
      check(kill_decode_q, 24'h00_0001);
      check(rti_clear_q, 24'h00_0000);
      step;
      check(rti_clear_q, 24'h00_0001);
      check(pc_stack_pointer, 24'h00_0001);
      check(pc_stack_top, 24'h00_0101);
      step;
      check(kill_decode_q, 24'h00_0001);
      check(rti_clear_q, 24'h00_0000);
      step;
      check(kill_decode_q, 24'h00_0000);
      step;
      $display("interrupt return done");
   endtask

   task automatic t_idle_irq;
      issue(bpc_pkg::BK_JUMP, 1'b1, 24'h00_0f00, 24'h00_1000);
      dec_idle = 1'b1;
      irq_raise = 1'b1;
      step;
      dec_idle = 1'b0;
      irq_raise = 1'b0;
      check(core_idle_q, 24'h00_0001);
      check(irq_pending, 24'h00_0001);
      step;
      check(core_idle_q, 24'h00_0001);
      check(irq_allow_q, 24'h00_0000);
      step;
      check(irq_allow_q, 24'h00_0001);
      check(core_idle_q, 24'h00_0001);
      step;
      check(core_idle_q, 24'h00_0000);
      step;
      $display("idle in slot done");
   endtask

   task automatic t_nested;
      keep_branch = 1'b1;
      issue(bpc_pkg::BK_JUMP, 1'b1, 24'h00_1100, 24'h00_1200);
      check(fetch_target_q, 24'h00_1200);
      slot_branch(24'h00_1300);
      keep_branch = 1'b0;
      check(fetch_redirect_q, 24'h00_0001);
      check(fetch_target_q, 24'h00_1300);
      repeat (5) step;
      check(fetch_target_q, 24'h00_1300);
      $display("nested delayed jump done");
   endtask

   task automatic t_excl;
      dec_conditional = 1'b1;
      keep_branch = 1'b1;
      issue(bpc_pkg::BK_JUMP, 1'b1, 24'h00_1400, 24'h00_1500);
      slot_branch(24'h00_1600);
      keep_branch = 1'b0;
      check(fetch_redirect_q, 24'h00_0000);
      check(fetch_target_q, 24'h00_1500);
      repeat (4) step;
      $display("exclusive conditional jumps done");
   endtask

   // slot code pushes after the call's own push, pops before returning
   task automatic t_slot_push;
      issue(bpc_pkg::BK_CALL, 1'b1, 24'h00_1700, 24'h00_1800);
      step;
      sw_push = 1'b1;
      sw_push_data = 24'h00_1234;
      step;
      sw_push = 1'b0;
      check(pc_stack_pointer, 24'h00_0003);
      check(pc_stack_top, 24'h00_1234);
      repeat (2) step;
      sw_pop = 1'b1;
      step;
      sw_pop = 1'b0;
      check(pc_stack_top, 24'h00_1703);
      issue(bpc_pkg::BK_RTS, 1'b0, 24'h00_1900, 24'h00_0000);
      check(fetch_target_q, 24'h00_1703);
      repeat (4) step;
      check(pc_stack_pointer, 24'h00_0001);
      $display("slot push and pop done");
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      n_errors = 0;
      samples_checked = 0;
      resetn = 1'b0;
      {dec_valid, dec_branch, delayed_branch_modifier} = 3'b000;
      {dec_conditional, dec_idle, sw_top_wr, irq_raise} = 4'b0000;
      dec_cond_true = 1'b1;
      dec_kind = bpc_pkg::BK_JUMP;
      dec_pc = 24'h00_0000;
      dec_target = 24'h00_0000;
      sw_top_data = 24'h00_0000;
      {sw_push, sw_pop, keep_branch} = 3'b000;
      sw_push_data = 24'h00_0000;
      repeat (16) step;
      resetn = 1'b1;
      check(irq_allow_q, 24'h00_0001);
      check(pc_stack_empty, 24'h00_0001);
      dec_valid = 1'b1;
      t_empty_write;
      t_imm_call;
      t_dly_call;
      t_dly_rts;
      t_rti;
      t_idle_irq;
      t_nested;
      t_excl;
      t_slot_push;
      give_verdict;
   end

   // whole run is near 80 cycles, so 5000 is ample
   initial begin
      #(5000 * 10);
      n_errors++;
      $display("Error at %0t ns: watchdog expired", $time);
      give_verdict;
   end
endmodule
`default_nettype wire
